/* verilog/lpm_params.svh */
// constants shared by the low-power mode controller files
`ifndef LPM_PARAMS_SVH
`define LPM_PARAMS_SVH
`define LPM_TIMER_RESET_VALUE 16'hfffc
`define LPM_TIMER_WIDTH 16
`endif

/* verilog/lpm_pkg.sv */
// types for the low-power mode controller
package lpm_pkg;
   typedef enum logic [2:0] {
      LPM_RUN = 3'h1,
      LPM_WAIT = 3'h2,
      LPM_STOP = 3'h4
   } lpm_mode_t;
endpackage : lpm_pkg

/* verilog/lpm_gate_if.sv */
// clock-gating enables handed from the mode controller to the peripherals
`timescale 1ns/1ps
`default_nettype none
interface lpm_gate_if;
   logic osc_run;
   logic cpu_run;
   logic in_stop;
   modport ctrl (output osc_run, output cpu_run, output in_stop);
   modport periph (input osc_run, input cpu_run, input in_stop);
endinterface : lpm_gate_if
`default_nettype wire

/* verilog/lpm_sync.sv */
// two-flop synchroniser for a pin-level input
`timescale 1ns/1ps
`default_nettype none
module lpm_sync (
   // clock and reset
   input wire logic i_clock,
   input wire logic i_reset_n,
   // data
   input wire logic i_async,
   output logic o_sync
);
   logic meta_ff;
   logic sync_ff;
   // resets to high because the pins it serves are active low
   always_ff @(posedge i_clock or negedge i_reset_n) begin
      if (!i_reset_n) begin
         meta_ff <= 1'h1;
         sync_ff <= 1'h1;
      end else begin
         meta_ff <= i_async;
         sync_ff <= meta_ff;
      end
   end
   assign o_sync = sync_ff;
endmodule : lpm_sync

/* verilog/lpm_timer.sv */
// free-running timer counter with stop-mode capture arming
`timescale 1ns/1ps
`default_nettype none
`include "lpm_params.svh"
module lpm_timer (
   // clock and reset
   input wire logic i_clock,
   input wire logic i_reset_n,
   // gating
   lpm_gate_if.periph gate,
   input wire logic i_wake_irq,
   // capture
   input wire logic i_capture_edge,
   input wire logic i_capture_clear,
   // status
   output logic [15:0] o_count,
   output logic o_capture_flag,
   output logic [15:0] o_capture_data
);
   logic [15:0] count_ff;
   logic armed_ff;
   logic [15:0] armed_data_ff;
   logic flag_ff;
   logic [15:0] cap_ff;

   // counter holds while oscillator is off; reset loads the fixed value
   always_ff @(posedge i_clock or negedge i_reset_n) begin
      if (!i_reset_n) begin
         count_ff <= `LPM_TIMER_RESET_VALUE; // [R4] [R20]
      end else if (gate.osc_run) begin
         count_ff <= count_ff + 16'h0001; // [R3] [R16] [R18]
      end
   end

   // first edge in stop only arms; reset throws it away
   always_ff @(posedge i_clock or negedge i_reset_n) begin
      if (!i_reset_n) begin
         armed_ff <= 1'h0; // [R6]
         armed_data_ff <= 16'h0000;
      end else if (i_wake_irq) begin
         armed_ff <= 1'h0; // consumed by the flag logic below
      end else if (gate.in_stop && i_capture_edge && !armed_ff) begin
         armed_ff <= 1'h1; // [R5]
         armed_data_ff <= count_ff;
      end
   end

   // flag: hardware set wins over software clear
   always_ff @(posedge i_clock or negedge i_reset_n) begin
      if (!i_reset_n) begin
         flag_ff <= 1'h0;
         cap_ff <= 16'h0000;
      end else if (i_wake_irq && armed_ff) begin
         flag_ff <= 1'h1; // [R5]
         cap_ff <= armed_data_ff;
      end else if (i_wake_irq && i_capture_edge) begin
         flag_ff <= 1'h1; // [R5] edge in the wake cycle itself
         cap_ff <= count_ff;
      end else if (!gate.in_stop && i_capture_edge) begin
         flag_ff <= 1'h1;
         cap_ff <= count_ff;
      end else if (i_capture_clear) begin
         flag_ff <= 1'h0;
      end
   end

   assign o_count = count_ff;
   assign o_capture_flag = flag_ff;
   assign o_capture_data = cap_ff;

   a_count_hold: assert property (@(posedge i_clock) disable iff (!i_reset_n) // [R3]
      gate.in_stop && $past(gate.in_stop) |-> count_ff == $past(count_ff))
      else $error("timer moved in stop");
   a_no_flag_stop: assert property (@(posedge i_clock) disable iff (!i_reset_n) // [R5]
      gate.in_stop && $past(gate.in_stop) && !$past(flag_ff) |-> !flag_ff)
      else $error("capture flag set during stop");
endmodule : lpm_timer
`default_nettype wire

/* verilog/lpm_ctrl.sv */
// low-power mode controller: stop and wait entry, wake-up and peripheral gating
`timescale 1ns/1ps
`default_nettype none
// How it works
// R1: stop turns oscillator off, freezing everything except slave spi shifting
// R2: stop ends on irq, reset, power-on
// R3: timer holds in stop, resumes after irq
// R4: reset exit loads timer with fffc
// R5: stop capture edge arms, flags after wake
// R6: reset exit discards stop capture edge
// R7: serial baud halts, transmission resumes after irq
// R8: serial receive mid-frame loses remaining bits
// R9: software idles serial unit before stop
// R10: spi master clock freezes until irq wake
// R11: reset exit clears spi bits, disables spi
// R12: slave spi keeps shifting during stop
// R13: slave completion flags only after irq wake
// R14: collision and fault detection off in stop
// R15: enabled output drivers stay active in stop
// R16: wait stops cpu clock only
// R17: wait ends on peripheral interrupt, irq, reset
// R18: timer always runs in wait
// R19: non-reset wait exit keeps peripheral state
// R20: reset wait exit returns peripherals to reset
// R21: one-cycle requests; wake clears mode immediately
module lpm_ctrl (
   // clock and reset
   input wire logic i_clock,
   input wire logic i_reset_n,
   // instruction decoder requests
   input wire logic i_stop_req,
   input wire logic i_wait_req,
   // pins, active low
   input wire logic i_ext_irq_n,
   // peripheral interrupts
   input wire logic i_timer_irq,
   input wire logic i_serial_irq,
   input wire logic i_spi_irq,
   // timer capture
   input wire logic i_capture_edge,
   input wire logic i_capture_clear,
   // spi state
   input wire logic i_spi_master,
   input wire logic i_spi_done,
   input wire logic i_spi_flag_clear,
   input wire logic i_spi_collision,
   input wire logic i_spi_fault,
   // serial receive state
   input wire logic i_serial_rx_busy,
   // mode and clock gating
   output logic o_in_stop,
   output logic o_in_wait,
   output logic o_cpu_clock_en,
   output logic o_osc_en,
   output logic o_serial_baud_en,
   output logic o_spi_master_clk_en,
   output logic o_spi_slave_en,
   output logic o_drivers_en,
   output logic o_wake,
   // serial receive
   output logic o_serial_rx_abort,
   // spi status
   output logic o_spi_done_flag,
   output logic o_write_collision_flag,
   output logic o_mode_fault_flag,
   // timer
   output logic [15:0] o_timer_count,
   output logic o_capture_flag,
   output logic [15:0] o_capture_data
);

////////////////////////////////////////////////////////////////////////////////
   // pin synchronisation

   logic irq_n_sync;
   lpm_sync u_irq_sync (
      .i_clock(i_clock),
      .i_reset_n(i_reset_n),
      .i_async(i_ext_irq_n),
      .o_sync(irq_n_sync)
   );

////////////////////////////////////////////////////////////////////////////////
   // mode state machine

   lpm_pkg::lpm_mode_t mode_ff;
   lpm_pkg::lpm_mode_t nxt_mode;
   logic irq_low;
   logic periph_irq;
   logic wake_stop;
   logic wake_wait;

   // mode decode in one place, so the wake terms and the gating cannot drift apart
   function automatic logic mode_is(input lpm_pkg::lpm_mode_t cur, input lpm_pkg::lpm_mode_t want);
      return cur == want;
   endfunction : mode_is

   assign irq_low = !irq_n_sync;
   // peripheral interrupts only matter in wait; in stop their clocks are dead anyway
   assign periph_irq = i_timer_irq | i_serial_irq | i_spi_irq;
   // reset pin and power-on both arrive as i_reset_n, which clears the mode
   assign wake_stop = mode_is(mode_ff, lpm_pkg::LPM_STOP) && irq_low; // [R2]
   assign wake_wait = mode_is(mode_ff, lpm_pkg::LPM_WAIT) && (irq_low || periph_irq); // [R17]

   // next mode; a wake-up takes priority over a fresh request in the same cycle
   always_comb begin
      nxt_mode = mode_ff;
      case (mode_ff)
         lpm_pkg::LPM_RUN: begin
            if (i_stop_req) begin
               nxt_mode = lpm_pkg::LPM_STOP; // [R21]
            end else if (i_wait_req) begin
               nxt_mode = lpm_pkg::LPM_WAIT; // [R21]
            end
         end
         lpm_pkg::LPM_WAIT: begin
            if (wake_wait) begin
               nxt_mode = lpm_pkg::LPM_RUN; // [R17] [R19]
            end
         end
         lpm_pkg::LPM_STOP: begin
            if (wake_stop) begin
               nxt_mode = lpm_pkg::LPM_RUN; // [R2]
            end
         end
         default: begin
            nxt_mode = lpm_pkg::LPM_RUN;
         end
      endcase
   end

   // reset exit from either mode lands here, peripherals reset alongside
   always_ff @(posedge i_clock or negedge i_reset_n) begin
      if (!i_reset_n) begin
         mode_ff <= lpm_pkg::LPM_RUN; // [R20]
      end else begin
         mode_ff <= nxt_mode;
      end
   end

////////////////////////////////////////////////////////////////////////////////
   // clock gating towards the peripherals

   lpm_gate_if gate();
   logic in_stop;
   logic in_wait;

   // decoded straight from the mode register, so these are clean levels
   assign in_stop = mode_is(mode_ff, lpm_pkg::LPM_STOP);
   assign in_wait = mode_is(mode_ff, lpm_pkg::LPM_WAIT);
   // combinational so the clocks stop in the very cycle the mode is entered
   assign gate.osc_run = !in_stop; // [R1]
   assign gate.cpu_run = !in_stop && !in_wait; // [R16]
   assign gate.in_stop = in_stop;

   assign o_in_stop = in_stop;
   assign o_in_wait = in_wait;
   assign o_osc_en = gate.osc_run; // [R1]
   assign o_cpu_clock_en = gate.cpu_run; // [R16]
   assign o_serial_baud_en = gate.osc_run; // [R7] [R16]
   assign o_spi_master_clk_en = gate.osc_run; // [R10] [R16]
   // slave shifting runs on the external clock, so it never stops
   assign o_spi_slave_en = 1'h1; // [R12]
   // no driver is turned off in stop; current draw is the user's concern
   assign o_drivers_en = 1'h1; // [R15]
   assign o_wake = wake_stop | wake_wait;

////////////////////////////////////////////////////////////////////////////////
   // serial receiver: a frame cut by stop cannot be completed

   // the receive sampling clock dies with the oscillator, so the partial frame is marked lost
   logic rx_abort_ff;
   always_ff @(posedge i_clock or negedge i_reset_n) begin
      if (!i_reset_n) begin
         rx_abort_ff <= 1'h0;
      end else begin
         rx_abort_ff <= (nxt_mode == lpm_pkg::LPM_STOP) && !in_stop && i_serial_rx_busy; // [R8]
      end
   end
   assign o_serial_rx_abort = rx_abort_ff;

////////////////////////////////////////////////////////////////////////////////
   // spi status, with the stop-mode deferral of the completion flag

   logic spi_pending_ff;
   logic spi_flag_ff;
   logic write_collision_flag_ff;
   logic mode_fault_flag_ff;

   // slave completion in stop is remembered and shown only after irq wake
   always_ff @(posedge i_clock or negedge i_reset_n) begin
      if (!i_reset_n) begin
         spi_pending_ff <= 1'h0; // [R11]
      end else if (wake_stop) begin
         spi_pending_ff <= 1'h0; // handed over to the flag below
      end else if (in_stop && i_spi_done && !i_spi_master) begin
         spi_pending_ff <= 1'h1; // [R13]
      end
   end

   // set wins over clear
   // a slave completion in the wake cycle itself goes straight to the flag, never left pending
   always_ff @(posedge i_clock or negedge i_reset_n) begin
      if (!i_reset_n) begin
         spi_flag_ff <= 1'h0; // [R11]
      end else if (wake_stop && (spi_pending_ff || (i_spi_done && !i_spi_master))) begin
         spi_flag_ff <= 1'h1; // [R13]
      end else if (!in_stop && i_spi_done) begin
         spi_flag_ff <= 1'h1;
      end else if (i_spi_flag_clear) begin
         spi_flag_ff <= 1'h0;
      end
   end

   // protection detectors are blind while stopped
   always_ff @(posedge i_clock or negedge i_reset_n) begin
      if (!i_reset_n) begin
         write_collision_flag_ff <= 1'h0; // [R11]
         mode_fault_flag_ff <= 1'h0;
      end else begin
         if (!in_stop && i_spi_collision) begin
            write_collision_flag_ff <= 1'h1; // [R14]
         end else if (i_spi_flag_clear) begin
            write_collision_flag_ff <= 1'h0;
         end
         if (!in_stop && i_spi_fault && i_spi_master) begin
            mode_fault_flag_ff <= 1'h1; // [R14]
         end else if (i_spi_flag_clear) begin
            mode_fault_flag_ff <= 1'h0;
         end
      end
   end

   assign o_spi_done_flag = spi_flag_ff;
   assign o_write_collision_flag = write_collision_flag_ff;
   assign o_mode_fault_flag = mode_fault_flag_ff;

////////////////////////////////////////////////////////////////////////////////
   // timer

   // the timer only hears the stop wake; a wait exit leaves its state alone
   lpm_timer u_timer (
      .i_clock(i_clock),
      .i_reset_n(i_reset_n),
      .gate(gate.periph),
      .i_wake_irq(wake_stop),
      .i_capture_edge(i_capture_edge),
      .i_capture_clear(i_capture_clear),
      .o_count(o_timer_count),
      .o_capture_flag(o_capture_flag),
      .o_capture_data(o_capture_data)
   );

////////////////////////////////////////////////////////////////////////////////
   // checks

   sequence s_stop_entry;
      (mode_ff == lpm_pkg::LPM_RUN) && i_stop_req;
   endsequence

   sequence s_stop_held;
      in_stop && !o_osc_en && !o_cpu_clock_en;
   endsequence

   sequence s_wait_entry;
      (mode_ff == lpm_pkg::LPM_RUN) && !i_stop_req && i_wait_req;
   endsequence

   sequence s_both_req;
      (mode_ff == lpm_pkg::LPM_RUN) && i_stop_req && i_wait_req;
   endsequence

   // a request that arrives in a low-power mode outside a wake cycle must be dropped
   sequence s_late_request;
      (mode_ff != lpm_pkg::LPM_RUN) && (i_stop_req || i_wait_req) && !o_wake;
   endsequence

   // mode entry, gating and wake checks
   a_stop_entry_osc: assert property (@(posedge i_clock) disable iff (!i_reset_n) // [R1]
      s_stop_entry |=> s_stop_held)
      else $error("stop request did not halt oscillator");
   a_stop_only_irq: assert property (@(posedge i_clock) disable iff (!i_reset_n) // [R2]
      in_stop && !irq_low |=> in_stop)
      else $error("stop left without irq");
   a_stop_wake_irq: assert property (@(posedge i_clock) disable iff (!i_reset_n) // [R21]
      in_stop && irq_low |=> (mode_ff == lpm_pkg::LPM_RUN))
      else $error("irq did not wake from stop");
   a_stop_clocks: assert property (@(posedge i_clock) disable iff (!i_reset_n) // [R7] [R10]
      in_stop |-> !o_serial_baud_en && !o_spi_master_clk_en)
      else $error("serial or spi master clock running in stop");
   a_wait_gating: assert property (@(posedge i_clock) disable iff (!i_reset_n) // [R16]
      in_wait |-> !o_cpu_clock_en && o_osc_en && o_serial_baud_en && o_spi_master_clk_en)
      else $error("wait gating wrong");
   a_run_clocks: assert property (@(posedge i_clock) disable iff (!i_reset_n) // [R16]
      !in_stop && !in_wait |-> o_cpu_clock_en && o_osc_en)
      else $error("clock gated while running");
   a_wait_entry: assert property (@(posedge i_clock) disable iff (!i_reset_n) // [R21]
      s_wait_entry |=> in_wait)
      else $error("wait request not taken");
   a_both_req_stop: assert property (@(posedge i_clock) disable iff (!i_reset_n) // [R21]
      s_both_req |=> in_stop)
      else $error("stop did not win over wait");
   a_late_request: assert property (@(posedge i_clock) disable iff (!i_reset_n) // [R21]
      s_late_request |=> mode_ff == $past(mode_ff))
      else $error("request changed mode outside run");
   a_wait_wake: assert property (@(posedge i_clock) disable iff (!i_reset_n) // [R17]
      in_wait && periph_irq |=> (mode_ff == lpm_pkg::LPM_RUN))
      else $error("peripheral interrupt did not end wait");
   a_wait_pin_wake: assert property (@(posedge i_clock) disable iff (!i_reset_n) // [R17]
      in_wait && irq_low |=> (mode_ff == lpm_pkg::LPM_RUN))
      else $error("irq pin did not end wait");
   a_wait_hold: assert property (@(posedge i_clock) disable iff (!i_reset_n) // [R17]
      in_wait && !irq_low && !periph_irq |=> in_wait)
      else $error("wait left without a wake source");
   a_wake_to_run: assert property (@(posedge i_clock) disable iff (!i_reset_n) // [R21]
      o_wake |=> (mode_ff == lpm_pkg::LPM_RUN))
      else $error("wake strobe did not return to run");

   // spi and serial checks
   a_spi_defer_flag: assert property (@(posedge i_clock) disable iff (!i_reset_n) // [R13]
      in_stop && i_spi_done && !i_spi_master && !irq_low ##1 in_stop |-> spi_pending_ff && !$rose(spi_flag_ff))
      else $error("slave completion flagged during stop");
   a_spi_flag_wake: assert property (@(posedge i_clock) disable iff (!i_reset_n) // [R13]
      wake_stop && spi_pending_ff |=> spi_flag_ff)
      else $error("deferred spi flag lost");
   a_spi_pending_clr: assert property (@(posedge i_clock) disable iff (!i_reset_n) // [R13]
      wake_stop |=> !spi_pending_ff)
      else $error("deferred spi completion left pending");
   a_protect_off: assert property (@(posedge i_clock) disable iff (!i_reset_n) // [R14]
      in_stop && !write_collision_flag_ff && !mode_fault_flag_ff |=> !write_collision_flag_ff && !mode_fault_flag_ff)
      else $error("protection flag set during stop");
   a_drivers_on: assert property (@(posedge i_clock) disable iff (!i_reset_n) // [R15]
      in_stop |-> o_drivers_en && o_spi_slave_en)
      else $error("drivers off in stop");
   a_rx_abort: assert property (@(posedge i_clock) disable iff (!i_reset_n) // [R8]
      (s_stop_entry and i_serial_rx_busy) |=> o_serial_rx_abort)
      else $error("receive abort missing");
   a_rx_abort_pulse: assert property (@(posedge i_clock) disable iff (!i_reset_n) // [R8]
      o_serial_rx_abort |=> !o_serial_rx_abort)
      else $error("receive abort longer than one cycle");
endmodule : lpm_ctrl
`default_nettype wire

/* testbench/lpm_periph_model.sv */
// far-side model: interrupt pin, peripheral events and status lines
`timescale 1ns/1ps
`default_nettype none
module lpm_periph_model (
   // clock
   input wire logic i_clock,
   // lines towards the controller, bit order fixed by the bench
   output logic [11:0] o_lines
);
   ////////////////////////////////////////////////////////////////////////
   // the irq pin has a pull-up, so it idles high when nobody pulls it
   logic [11:0] lvl = 12'h001;
   assign o_lines = lvl;
   // lines move just after the falling edge, clear of the sampling edge
   task automatic set_line(input int unsigned idx, input logic v);
      @(negedge i_clock);
      lvl[idx] = v;
   endtask : set_line
   // one-cycle event, as a peripheral detector reports it
   task automatic pulse(input int unsigned idx);
      set_line(idx, 1'b1);
      set_line(idx, 1'b0);
   endtask : pulse
endmodule : lpm_periph_model
`default_nettype wire

/* testbench/lpm_ctrl_tb_top.sv */
// self-checking bench for the low-power mode controller
`timescale 1ns/1ps
`default_nettype none
module lpm_ctrl_tb_top;
   localparam int PIN = 0, TIRQ = 1, CAP = 4, CCLR = 5, MST = 6, DONE = 7;
   localparam int FCLR = 8, COL = 9, FLT = 10, RXB = 11;
   logic i_clock = 1'b0, i_reset_n = 1'b0, i_stop_req = 1'b0, i_wait_req = 1'b0;
   logic i_ext_irq_n, i_timer_irq, i_serial_irq, i_spi_irq, i_capture_edge, i_capture_clear;
   logic i_spi_master, i_spi_done, i_spi_flag_clear, i_spi_collision, i_spi_fault, i_serial_rx_busy;
   logic o_in_stop, o_in_wait, o_cpu_clock_en, o_osc_en, o_serial_baud_en, o_spi_master_clk_en;
   logic o_spi_slave_en, o_drivers_en, o_wake, o_serial_rx_abort, o_spi_done_flag;
   logic o_write_collision_flag, o_mode_fault_flag, o_capture_flag;
   logic [15:0] o_timer_count, o_capture_data, held, c0;
   logic [11:0] lines;
   int n_mismatch = 0, num_checks = 0, cycles = 0, seen;
   ////////////////////////////////////////////////////////////////////////
   // far side and device under test
   assign {i_serial_rx_busy, i_spi_fault, i_spi_collision, i_spi_flag_clear, i_spi_done, i_spi_master,
      i_capture_clear, i_capture_edge, i_spi_irq, i_serial_irq, i_timer_irq, i_ext_irq_n} = lines;
   lpm_periph_model lpm_periph_model_inst (.i_clock(i_clock), .o_lines(lines));
   lpm_ctrl lpm_ctrl_inst (.*);
   // 125 MHz clock
   initial begin
      forever #4 i_clock = ~i_clock;
   end
   // a hang is cut short well past the expected run length
   always @(posedge i_clock) begin
      cycles++;
      if (cycles == 3000) begin
         n_mismatch++;
         stop_test();
      end
   end
   ////////////////////////////////////////////////////////////////////////
   task automatic check(input string what, input logic [15:0] got, input logic [15:0] exp);
      num_checks++;
      if (got !== exp) begin
         n_mismatch++;
         $display("FAIL %s expected %h seen %h", what, exp, got);
      end
   endtask : check
   task automatic stop_test();
      $display("checks %0d mismatches %0d", num_checks, n_mismatch);
      if (n_mismatch == 0 && num_checks > 0) $display("NO MISMATCHES");
      else $display("MISMATCHES SEEN");
      $finish;
   endtask : stop_test
   task automatic cyc(input int n);
      repeat (n) @(negedge i_clock);
   endtask : cyc
   // decoder requests are single-cycle pulses
   task automatic req(input logic s, input logic w);
      @(negedge i_clock);
      i_stop_req = s;
      i_wait_req = w;
      @(negedge i_clock);
      i_stop_req = 1'b0;
      i_wait_req = 1'b0;
   endtask : req
   // bounded wait for the wake strobe, then one edge to return to run
   task automatic wait_wake();
      // let a line changed in this time step reach the combinational wake strobe
      #1;
      for (int k = 0; k < 8 && o_wake !== 1'b1; k++) cyc(1);
      check("wake", o_wake, 1);
      cyc(1);
   endtask : wait_wake
   task automatic wake_pin();
      lpm_periph_model_inst.set_line(PIN, 1'b0);
      wait_wake();
      lpm_periph_model_inst.set_line(PIN, 1'b1);
   endtask : wake_pin
   ////////////////////////////////////////////////////////////////////////
   task automatic t_reset();
      check("mode", {o_in_stop, o_in_wait, o_cpu_clock_en, o_osc_en}, 16'h3);
      check("count", o_timer_count, 16'hfffc);
      check("flags", {o_capture_flag, o_spi_done_flag, o_write_collision_flag, o_mode_fault_flag}, 0);
      cyc(4);
      check("count run", o_timer_count, 16'h0000);
   endtask : t_reset
   // stop with slave traffic, capture and ignored events, then pin wake
   task automatic t_stop_irq();
      req(1'b1, 1'b0);
      check("stop", {o_in_stop, o_cpu_clock_en, o_osc_en}, 16'h4);
      check("clk en", {o_serial_baud_en, o_spi_master_clk_en}, 0);
      check("slave drv", {o_spi_slave_en, o_drivers_en}, 16'h3);
      held = o_timer_count;
      lpm_periph_model_inst.pulse(CAP);
      lpm_periph_model_inst.pulse(DONE);
      lpm_periph_model_inst.pulse(COL);
      lpm_periph_model_inst.pulse(FLT);
      lpm_periph_model_inst.set_line(TIRQ, 1'b1);
      check("no wake", {o_wake, o_in_stop}, 16'h1);
      lpm_periph_model_inst.set_line(TIRQ, 1'b0);
      req(1'b0, 1'b1);
      check("no wait", o_in_wait, 0);
      check("held", o_timer_count, held);
      check("quiet", {o_capture_flag, o_spi_done_flag, o_write_collision_flag, o_mode_fault_flag}, 0);
      wake_pin();
      check("run", {o_in_stop, o_cpu_clock_en}, 16'h1);
      check("cap", {o_capture_flag, o_spi_done_flag, o_write_collision_flag}, 16'h6);
      check("cap data", o_capture_data, held);
      c0 = o_timer_count;
      check("resume", 16'(c0 - held <= 16'h0003), 16'h1);
      cyc(3);
      check("count", o_timer_count, c0 + 16'h3);
      lpm_periph_model_inst.pulse(CCLR);
      lpm_periph_model_inst.pulse(FCLR);
      check("cleared", {o_capture_flag, o_spi_done_flag}, 0);
   endtask : t_stop_irq
   // stop left through reset discards the armed edge and spi status
   task automatic t_stop_reset();
      req(1'b1, 1'b0);
      lpm_periph_model_inst.pulse(CAP);
      lpm_periph_model_inst.pulse(DONE);
      i_reset_n = 1'b0;
      cyc(2);
      check("rst count", o_timer_count, 16'hfffc);
      check("rst flag", o_capture_flag, 0);
      check("rst cap", o_capture_data, 16'h0000);
      check("rst spi", {o_spi_done_flag, o_in_stop}, 0);
      i_reset_n = 1'b1;
      cyc(2);
      check("rst exit cap", o_capture_flag, 0);
      check("rst exit count", o_timer_count, 16'hfffe);
   endtask : t_stop_reset
   // wait left by each interrupt source; peripherals keep running and state
   task automatic t_wait();
      for (int s = 0; s < 4; s++) begin
         req(1'b0, 1'b1);
         check("wait", {o_in_wait, o_cpu_clock_en, o_osc_en, o_serial_baud_en, o_spi_master_clk_en}, 16'h17);
         c0 = o_timer_count;
         req(1'b1, 1'b0);
         check("no stop", o_in_stop, 0);
         check("tmr wait", o_timer_count, c0 + 16'h2);
         if (s == 0) begin
            lpm_periph_model_inst.set_line(MST, 1'b1);
            lpm_periph_model_inst.pulse(FLT);
            lpm_periph_model_inst.pulse(COL);
         end
         lpm_periph_model_inst.set_line(s, s != 0);
         wait_wake();
         lpm_periph_model_inst.set_line(s, s == 0);
         check("left", o_in_wait, 0);
         check("kept", {o_write_collision_flag, o_mode_fault_flag}, 16'h3);
      end
   endtask : t_wait
   // receiver busy at stop entry; stop beats wait when both arrive
   task automatic t_rx_abort();
      lpm_periph_model_inst.set_line(RXB, 1'b1);
      req(1'b1, 1'b1);
      check("stop wins", {o_in_stop, o_in_wait}, 16'h2);
      seen = 0;
      for (int k = 0; k < 4; k++) begin
         seen += int'(o_serial_rx_abort === 1'b1);
         cyc(1);
      end
      check("rx abort", 16'(seen), 16'h1);
      lpm_periph_model_inst.set_line(RXB, 1'b0);
      wake_pin();
   endtask : t_rx_abort
   ////////////////////////////////////////////////////////////////////////
   // main sequence after the reset hold
   initial begin
      cyc(12);
      i_reset_n = 1'b1;
      t_reset();
      t_stop_irq();
      t_stop_reset();
      t_wait();
      t_rx_abort();
      stop_test();
   end
endmodule : lpm_ctrl_tb_top
`default_nettype wire
